//--- inc/encoder_spi_consts.svh
// frame layout, check code and timing constants of the encoder spi position port
`ifndef ENCODER_SPI_CONSTS_SVH
`define ENCODER_SPI_CONSTS_SVH

// frame geometry
`define FRAME_BITS     48
`define FRAME_CNT_W    6
`define PAD_MSB        47
`define PAD_LSB        33
`define ZERO_REF_BIT   32
`define VALID_BIT      31
`define SYNC_BIT       30
`define ANGLE_MSB      29
`define ANGLE_LSB      8
`define ANGLE_W        22
`define REPEAT_BIT     7
`define CRC_MSB        6
`define CRC_LSB        0

// resolution of the angle source; msbs above it are sent as zero
`define RESOLUTION     22

// check code
`define CRC_W          7
`define CRC_POLY       7'h5b
`define CRC_INIT       7'h00
`define CRC_WORD_W     32
`define CRC_COVER_MSB  32
`define CRC_COVER_LSB  7
`define CRC_COVER_W    26

// timing, clk_sys period and documented times in ns
`define CLK_PERIOD_NS  100
`define IDLE_MAX_NS    10000
`define IDLE_CYCLES    ((`IDLE_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDLE_CNT_W     7
`define MTO_NS         135000
`define MTO_CYCLES     ((`MTO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MTO_CNT_W      11

// reset values of the held sample
`define RST_ANGLE      22'h000000
`define RST_ZERO_REF   1'h1
`define RST_VALID      1'h0
`define RST_SYNC       1'h0
`define RST_REPEAT     1'h1

`endif

//--- inc/encoder_spi_pkg.sv
// types shared by the encoder spi position port
package encoder_spi_pkg;

  // serial frame engine
  typedef enum logic [0:0] {
    FRAME_IDLE  = 1'b0,
    FRAME_SHIFT = 1'b1
  } frame_state_t;

  // measurement scheduler
  typedef enum logic [0:0] {
    SCHED_IDLE    = 1'b0,
    SCHED_PENDING = 1'b1
  } sched_state_t;

endpackage : encoder_spi_pkg

//--- hw/measure_scheduler.sv
// trigger scheduler for position measurements: frame start or timeout
`timescale 1ns/10ps
`include "encoder_spi_consts.svh"

module measure_scheduler (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // events from the frame engine and the measurement core
  input  wire logic frame_start,
  input  wire logic meas_done,
  // trigger towards the measurement core
  output logic      meas_start,
  output logic      meas_pending,
  output logic      trig_by_frame
);
  import encoder_spi_pkg::*;

  sched_state_t                 state;
  sched_state_t                 next_state;
  logic [`MTO_CNT_W-1:0]        mto_cnt;
  logic [`MTO_CNT_W-1:0]        next_mto_cnt;
  logic                         next_meas_start;
  logic                         next_trig_by_frame;
  logic                         timeout;
  logic                         frame_trig;

  // timeout counts from the last trigger, frame start only if nothing pending
  assign timeout    = (mto_cnt == `MTO_CNT_W'(`MTO_CYCLES - 1));
  assign frame_trig = frame_start && (state == SCHED_IDLE);

  // next trigger state; an overdue core is retriggered rather than waited on forever
  always_comb begin
    next_state         = state;
    next_mto_cnt       = mto_cnt;
    next_meas_start    = 1'b0;
    next_trig_by_frame = trig_by_frame;
    if (timeout) begin
      next_state         = SCHED_PENDING;
      next_mto_cnt       = '0;
      next_meas_start    = 1'b1;
      next_trig_by_frame = 1'b0;
    end else if (frame_trig) begin
      next_state         = SCHED_PENDING;
      next_mto_cnt       = '0;
      next_meas_start    = 1'b1;
      next_trig_by_frame = 1'b1;
    end else begin
      next_mto_cnt = mto_cnt + `MTO_CNT_W'(1);
      if (meas_done) begin
        next_state = SCHED_IDLE;
      end
    end
  end

  // registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state         <= SCHED_IDLE;
      mto_cnt       <= '0;
      meas_start    <= 1'b0;
      trig_by_frame <= 1'b0;
    end else begin
      state         <= next_state;
      mto_cnt       <= next_mto_cnt;
      meas_start    <= next_meas_start;
      trig_by_frame <= next_trig_by_frame;
    end
  end

  assign meas_pending = (state == SCHED_PENDING);

endmodule : measure_scheduler

//--- hw/encoder_spi_position_frame.sv
// spi slave that sends the 48-bit single-turn position frame
`timescale 1ns/10ps
`include "encoder_spi_consts.svh"

// Summary of operation
// - clock idles high; master samples on falling edge, data changes on rising edge.
// - every bit is paced only by the master's serial clock.
// - one frame is six bytes, 48 bits of position, flags and check code.
// - frame bits 47 down to 33 are always zero.
// - bit 32 is one while the zero reference is the factory value.
// - bit 31 is one when the sent position is valid.
// - bit 30 is one when a frame, not the timeout, started the measurement.
// - bits 29 to 8 hold the angle, unused msbs zero.
// - bit 7 is one when this sample was already sent before.
// - bits 6 to 0 are crc7, poly 0x5b, init zero, msb first, no xor.
// - check code covers bits 32..7 in a 32-bit word, top six zero.
// - timeout after the last trigger starts a measurement; frames trigger only if idle.
// - each frame reports the latest completed measurement and its flags.
// - clock idle for the maximum period resets the frame; next fall starts anew.
module encoder_spi_position_frame (
  // system clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // serial link
  input  wire logic                sclk,
  output logic                     sdo,
  // measurement core
  output logic                     meas_start,
  input  wire logic                meas_done,
  input  wire logic [`ANGLE_W-1:0] meas_angle,
  input  wire logic                meas_valid,
  input  wire logic                zero_ref_factory,
  // status
  output logic                     frame_active,
  output logic                     meas_pending
);
  import encoder_spi_pkg::*;

  // crc7 over a word, msb first, no final inversion
  // the register starts at zero and each data bit is folded in from the top;
  // a loop is cheap here because the word width is fixed and it unrolls
  function automatic logic [`CRC_W-1:0] crc7(input logic [`CRC_WORD_W-1:0] word);
    logic [`CRC_W-1:0] c;
    logic              fb;
    integer            i;
    c = `CRC_INIT;
    for (i = `CRC_WORD_W - 1; i >= 0; i--) begin
      fb = c[`CRC_W-1] ^ word[i];
      c  = {c[`CRC_W-2:0], 1'b0};
      if (fb) begin
        c = c ^ `CRC_POLY;
      end
    end
    return c;
  endfunction : crc7

  // clear angle bits at and above the device resolution
  function automatic logic [`ANGLE_W-1:0] angle_mask(input logic [`ANGLE_W-1:0] a);
    logic [`ANGLE_W-1:0] m;
    integer              i;
    m = '0;
    for (i = 0; i < `ANGLE_W; i++) begin
      m[i] = (i < `RESOLUTION) ? a[i] : 1'b0;
    end
    return m;
  endfunction : angle_mask

  // ------------------------------------------------------------------
  // reset release: asserts at once, releases two edges later
  // the internal copy rst_n feeds every other flop, so a release that lands
  // near a clock edge cannot split the state machines across two cycles
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ------------------------------------------------------------------
  // serial clock synchroniser and edge finder
  // limitation: at 10 MHz sampling the usable link clock is well below 5 MHz
  // sclk comes straight from a pin, so it passes two flops before any logic;
  // the third stage only remembers the last synchronised level for edge finding
  // each detected edge arrives one to two clk_sys cycles after the pin moves
  logic sclk_meta;
  logic sclk_sync;
  logic sclk_prev;
  logic sclk_fall;
  logic sclk_rise;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_meta <= 1'b1;
      sclk_sync <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      sclk_meta <= sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
    end
  end

  // only the second and third stages are compared
  assign sclk_fall = sclk_prev & ~sclk_sync;
  assign sclk_rise = ~sclk_prev & sclk_sync;

  // ------------------------------------------------------------------
  // idle watchdog: counts high clock time, saturates at the limit
  // any low level or a fresh rise clears it, so only a long high stretch counts;
  // once saturated the flag stays up until the master pulls the clock low again
  // the limit sits just above the longest legal pause between bytes
  logic [`IDLE_CNT_W-1:0] idle_cnt;
  logic [`IDLE_CNT_W-1:0] next_idle_cnt;
  logic                   idle_expired;

  assign idle_expired = (idle_cnt == `IDLE_CNT_W'(`IDLE_CYCLES));

  always_comb begin
    next_idle_cnt = idle_cnt;
    if (!sclk_sync || sclk_rise) begin
      next_idle_cnt = '0;
    end else if (!idle_expired) begin
      next_idle_cnt = idle_cnt + `IDLE_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= next_idle_cnt;
    end
  end

  // ------------------------------------------------------------------
  // measurement scheduler
  // the scheduler owns the trigger and the timeout; the core only reports
  // completion, and trig_by_frame tells which source started the measurement
  logic frame_start;
  logic trig_by_frame;

  measure_scheduler u_sched (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .frame_start   (frame_start),
    .meas_done     (meas_done),
    .meas_start    (meas_start),
    .meas_pending  (meas_pending),
    .trig_by_frame (trig_by_frame)
  );

  // ------------------------------------------------------------------
  // held sample: latest completed measurement with its flags
  logic [`ANGLE_W-1:0] samp_angle;
  logic                samp_valid;
  logic                samp_sync;
  logic                samp_zero_ref;
  logic                samp_repeat;
  logic [`ANGLE_W-1:0] next_samp_angle;
  logic                next_samp_valid;
  logic                next_samp_sync;
  logic                next_samp_zero_ref;
  logic                next_samp_repeat;

  // the sample is what the next frame will send, so it only changes on a
  // completed measurement; the repeat flag is the only bit a frame start touches
  // hazard: sending the live zero reference instead would let bit 32 disagree
  // with the angle that goes out beside it
  // a sample completing as a frame starts stays fresh for the next frame
  always_comb begin
    next_samp_angle    = samp_angle;
    next_samp_valid    = samp_valid;
    next_samp_sync     = samp_sync;
    next_samp_zero_ref = samp_zero_ref;
    next_samp_repeat   = samp_repeat;
    if (meas_done) begin
      next_samp_angle    = meas_angle;
      next_samp_valid    = meas_valid;
      next_samp_sync     = trig_by_frame;
      next_samp_zero_ref = zero_ref_factory;
      next_samp_repeat   = 1'b0;
    end else if (frame_start) begin
      next_samp_repeat   = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      samp_angle    <= `RST_ANGLE;
      samp_valid    <= `RST_VALID;
      samp_sync     <= `RST_SYNC;
      samp_zero_ref <= `RST_ZERO_REF;
      samp_repeat   <= `RST_REPEAT;
    end else begin
      samp_angle    <= next_samp_angle;
      samp_valid    <= next_samp_valid;
      samp_sync     <= next_samp_sync;
      samp_zero_ref <= next_samp_zero_ref;
      samp_repeat   <= next_samp_repeat;
    end
  end

  // ------------------------------------------------------------------
  // frame word assembled from the held sample
  // bit map of the word, top to bottom:
  //   47..33  zero padding
  //   32      zero_ref_factory_flag
  //   31      position_valid_flag
  //   30      frame_synced_flag
  //   29..8   angle_field
  //   7       repeat_sample_flag
  //   6..0    check code over bits 32..7
  // crc_word keeps its six top bits at zero
  logic [`FRAME_BITS-1:0]  frame_word;
  logic [`CRC_WORD_W-1:0]  crc_word;

  always_comb begin
    frame_word                           = '0;
    frame_word[`ZERO_REF_BIT]            = samp_zero_ref;
    frame_word[`VALID_BIT]               = samp_valid;
    frame_word[`SYNC_BIT]                = samp_sync;
    frame_word[`ANGLE_MSB:`ANGLE_LSB]    = angle_mask(samp_angle);
    frame_word[`REPEAT_BIT]              = samp_repeat;
    crc_word                             = '0;
    crc_word[`CRC_COVER_W-1:0]           = frame_word[`CRC_COVER_MSB:`CRC_COVER_LSB];
    frame_word[`CRC_MSB:`CRC_LSB]        = crc7(crc_word);
  end

  // ------------------------------------------------------------------
  // frame engine
  // no select line exists, so bit 47 (always zero) rests on the line before the
  // first fall; the frame is captured on that fall and later bits move on rises
  // bit_cnt counts captured falls; the 48th fall closes the frame and clears
  // the shifter so the line rests at zero between frames
  // trade-off: ending on the fall rather than the next rise lets frames run
  // back to back without a gap
  // an abort mid-frame drops the partial word; the master sees a bad check code
  frame_state_t            state;
  frame_state_t            next_state;
  logic [`FRAME_CNT_W-1:0] bit_cnt;
  logic [`FRAME_CNT_W-1:0] next_bit_cnt;
  logic [`FRAME_BITS-1:0]  shreg;
  logic [`FRAME_BITS-1:0]  next_shreg;

  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    frame_start  = 1'b0;
    unique case (state)
      FRAME_IDLE: begin
        if (sclk_fall) begin
          frame_start  = 1'b1;
          next_state   = FRAME_SHIFT;
          next_bit_cnt = `FRAME_CNT_W'(1);
          next_shreg   = frame_word;
        end
      end
      FRAME_SHIFT: begin
        if (idle_expired) begin
          next_state   = FRAME_IDLE;
          next_bit_cnt = '0;
          next_shreg   = '0;
        end else if (sclk_fall) begin
          if (bit_cnt == `FRAME_CNT_W'(`FRAME_BITS - 1)) begin
            next_state   = FRAME_IDLE;
            next_bit_cnt = '0;
            next_shreg   = '0;
          end else begin
            next_bit_cnt = bit_cnt + `FRAME_CNT_W'(1);
          end
        end else if (sclk_rise) begin
          next_shreg = {shreg[`FRAME_BITS-2:0], 1'b0};
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state   <= FRAME_IDLE;
      bit_cnt <= '0;
      shreg   <= '0;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
    end
  end

  // serial data straight from the top flop of the shifter
  // frame_active follows the state register, so it is free of glitches
  assign sdo          = shreg[`FRAME_BITS-1];
  assign frame_active = (state == FRAME_SHIFT);

endmodule : encoder_spi_position_frame

//--- tb/encoder_spi_frame_props.sv
// port-level assertions for the encoder spi position port
`timescale 1ns/10ps
module encoder_spi_frame_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial link
  input wire logic sclk,
  input wire logic sdo,
  // measurement and status
  input wire logic meas_start,
  input wire logic meas_done,
  input wire logic frame_active,
  input wire logic meas_pending
);
  logic       sclk_q, next_sclk_q;
  logic [5:0] falls, next_falls;
  logic [6:0] hi_cnt, next_hi_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // raw sclk counters; they run ahead of the design's synchroniser, so bounds keep margin
  always_comb begin
    next_sclk_q = sclk;
    next_falls  = frame_active ? falls + {5'h00, sclk_q & ~sclk} : 6'h00;
    next_hi_cnt = !sclk ? 7'h00 : hi_cnt + {6'h00, hi_cnt != 7'h7f};
  end
  // registers of the counters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclk_q <= 1'b1;
      falls  <= 6'h00;
      hi_cnt <= 7'h00;
    end else begin
      sclk_q <= next_sclk_q;
      falls  <= next_falls;
      hi_cnt <= next_hi_cnt;
    end
  end
  property p_start_pulse; meas_start |=> !meas_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  property p_pend_start; meas_start |-> meas_pending; endproperty
  a_pend_start: assert property (p_pend_start) else $error("start not pending");
  property p_frame_trig; $rose(frame_active) && !$past(meas_pending) |-> meas_start; endproperty
  a_frame_trig: assert property (p_frame_trig) else $error("frame no trigger");
  property p_done_clear; meas_done && meas_pending |=> !meas_pending || meas_start; endproperty
  a_done_clear: assert property (p_done_clear) else $error("pending stuck");
  property p_idle_sdo; !frame_active |-> !sdo; endproperty
  a_idle_sdo: assert property (p_idle_sdo) else $error("sdo high idle");
  property p_sdo_high; frame_active && $changed(sdo) |-> sclk; endproperty
  a_sdo_high: assert property (p_sdo_high) else $error("sdo moved low");
  property p_frame_len; falls <= 6'h2f; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame too long");
  property p_pad_zero; frame_active && falls <= 6'h0d |-> !sdo; endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("pad not zero");
  property p_abort; hi_cnt >= 7'h6e |-> !frame_active; endproperty
  a_abort: assert property (p_abort) else $error("no idle abort");
  property p_begin; $fell(sclk) && !frame_active |-> ##[1:4] frame_active; endproperty
  a_begin: assert property (p_begin) else $error("frame not begun");
endmodule : encoder_spi_frame_props

bind encoder_spi_position_frame encoder_spi_frame_props i_encoder_spi_frame_props (
  .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .sdo(sdo), .meas_start(meas_start),
  .meas_done(meas_done), .frame_active(frame_active), .meas_pending(meas_pending));

//--- tb/spi_master_model.sv
// behavioural spi master that clocks frames out of the port
`timescale 1ns/10ps
module spi_master_model (
  // serial link
  output logic      sclk,
  input  wire logic sdo,
  // frame in progress
  output logic      busy
);
  // clock rests high between frames
  initial begin
    sclk = 1'b1;
    busy = 1'b0;
  end
  // 800 ns bit time; data taken at each fall, msb first
  task automatic xfer(input int n, output logic [47:0] w);
    #17;
    w = 48'h0;
    busy = 1'b1;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      w = {w[46:0], sdo};
      #400;
      sclk = 1'b1;
      #400;
    end
    busy = 1'b0;
  endtask : xfer
endmodule : spi_master_model

//--- tb/tb_top.sv
// self-checking bench for the encoder spi position port
`timescale 1ns/10ps
`include "encoder_spi_consts.svh"
module tb_top;
  logic                clk_sys, resetn, sclk, sdo, busy, src;
  logic                meas_start, meas_done, meas_valid, zero_ref_factory;
  logic                frame_active, meas_pending;
  logic [`ANGLE_W-1:0] meas_angle, s_ang, nang;
  logic                s_zr, s_vld, s_sync, s_rep, nzr, nvld;
  logic [47:0]         w, exp_frame;
  int                  num_errors, checks, n_start, lat, cyc;

  encoder_spi_position_frame i_encoder_spi_position_frame (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .sdo(sdo),
    .meas_start(meas_start), .meas_done(meas_done), .meas_angle(meas_angle),
    .meas_valid(meas_valid), .zero_ref_factory(zero_ref_factory),
    .frame_active(frame_active), .meas_pending(meas_pending));
  spi_master_model i_spi_master_model (.sclk(sclk), .sdo(sdo), .busy(busy));

  // check code worked out bit by bit, msb first
  function automatic logic [6:0] crc7(input logic [31:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h5b : 7'h00);
    end
    return c;
  endfunction : crc7
  // expected frame from a held sample
  function automatic logic [47:0] mk(input logic zr, v, sy, input logic [21:0] a, input logic r);
    logic [25:0] cov;
    cov = {zr, v, sy, a, r};
    return {15'h0000, cov, crc7({6'h00, cov})};
  endfunction : mk
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] ex);
    checks++;
    if (seen !== ex) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  always #50 clk_sys = ~clk_sys;
  // cycle ceiling well above the planned run of about 4500 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      finish_test();
    end
  end
  // frame start takes the held sample and marks it as sent
  always @(posedge busy) begin
    exp_frame = mk(s_zr, s_vld, s_sync, s_ang, s_rep);
    s_rep = 1'b1;
  end
  // measurement core: answers each trigger after lat cycles
  always begin
    @(posedge clk_sys iff meas_start === 1'b1);
    n_start++;
    src = busy;
    repeat (lat) @(negedge clk_sys);
    meas_done = 1'b1;
    meas_angle = nang;
    meas_valid = nvld;
    zero_ref_factory = nzr;
    @(negedge clk_sys);
    meas_done = 1'b0;
    {s_ang, s_vld, s_zr, s_sync, s_rep} = {nang, nvld, nzr, src, 1'b0};
    nang = {nang[20:0], ~nang[21]};
  end
  // main sequence
  initial begin
    {clk_sys, resetn, meas_done, meas_valid, zero_ref_factory, nzr} = 6'h00;
    meas_angle = 22'h000000;
    {s_ang, s_vld, s_zr, s_sync, s_rep} = {22'h000000, 4'h5};
    nang = 22'h3fffff;
    nvld = 1'b1;
    lat = 40;
    repeat (20) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("idle", 48'({sdo, meas_start, frame_active, meas_pending}), 48'h0);
    for (int k = 0; k < 3; k++) begin
      i_spi_master_model.xfer(48, w);
      check("frame", w, exp_frame);
    end
    check("starts", 48'(n_start), 48'h3);
    lat = 500;
    nzr = 1'b1;
    i_spi_master_model.xfer(48, w);
    check("frame", w, exp_frame);
    i_spi_master_model.xfer(48, w);
    check("repeat", 48'(w[7]), 48'h1);
    check("frame", w, exp_frame);
    check("starts", 48'(n_start), 48'h4);
    lat = 40;
    nvld = 1'b0;
    repeat (1500) @(negedge clk_sys);
    check("starts", 48'(n_start), 48'h5);
    i_spi_master_model.xfer(48, w);
    check("flags", 48'({w[47:30], w[7]}), 48'({exp_frame[47:30], exp_frame[7]}));
    nzr = 1'b0;
    nvld = 1'b1;
    i_spi_master_model.xfer(10, w);
    check("partial", 48'(w[9:0]), 48'(exp_frame[47:38]));
    #15000;
    i_spi_master_model.xfer(48, w);
    check("resync", w, exp_frame);
    finish_test();
  end
endmodule : tb_top
